// ### core/tcc_top.sv
`timescale 1ns/1ns
module tcc_top #(
  parameter int COUNT_W = 16 // Counter and capture width
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [tcc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tcc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [tcc_pkg::DATA_W-1:0] RDATA,
  input wire logic TIMER_INPUT_PIN_A,
  input wire logic TIMER_INPUT_PIN_B,
  output logic TIMER_OUTPUT_PIN,
  output logic TIMER_OUTPUT_PIN_EN,
  output logic INTERRUPT_REQUEST_A,
  output logic INTERRUPT_REQUEST_B
);

  // Refuse counter widths outside 2 to 16 bits
  generate
    if (COUNT_W < 2 || COUNT_W > 16) begin : g_bad_width
      $error("COUNT_W must lie between 2 and 16");
    end
  endgenerate

  localparam logic [COUNT_W-1:0] CNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};
  localparam logic [COUNT_W-1:0] CNT_ZERO = '0;
  localparam logic [tcc_pkg::PRE_W-1:0] PRE_ONE = 4'h1;
  localparam logic [tcc_pkg::PRE_W-1:0] PRE_ZERO = 4'h0;

  // Edge detectors for both input pins
  tcc_edge_if pin_a ();
  tcc_edge_if pin_b ();

  tcc_edge_sync u_sync_a (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .pin(TIMER_INPUT_PIN_A),
    .ev(pin_a)
  );

  tcc_edge_sync u_sync_b (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .pin(TIMER_INPUT_PIN_B),
    .ev(pin_b)
  );

  // Configuration state
  logic [31:0] ctrl_r; // Control bits
  logic [31:0] ctrl_nxt;

  // Timer core state
  logic [tcc_pkg::PRE_W-1:0] pre_r; // Prescaler count
  logic [tcc_pkg::PRE_W-1:0] pre_nxt;
  logic [COUNT_W-1:0] cnt_r; // COUNT_W-bit counter
  logic [COUNT_W-1:0] cnt_nxt;
  logic [COUNT_W-1:0] cra_r; // Capture/compare register A
  logic [COUNT_W-1:0] cra_nxt;
  logic [COUNT_W-1:0] crb_r; // Capture/compare register B
  logic [COUNT_W-1:0] crb_nxt;
  logic out_r; // Timer output level
  logic out_nxt;
  logic out_en_r; // Timer output enable
  logic out_en_nxt;
  logic irq_a_r; // Interrupt request A pulse
  logic irq_a_nxt;
  logic irq_b_r; // Interrupt request B pulse
  logic irq_b_nxt;

  // Read-back state
  logic [tcc_pkg::DATA_W-1:0] rdata_r;
  logic [tcc_pkg::DATA_W-1:0] rdata_nxt;

  // Decoded control fields
  tcc_pkg::tcc_mode_type mode;
  logic run;
  logic css;
  logic a_cap;
  logic b_cap;
  logic [1:0] esa;
  logic [1:0] esb;
  logic [tcc_pkg::PRE_W-1:0] pre_sel;

  // Events of this cycle
  logic tick;
  logic a_edge;
  logic a_rev;
  logic b_edge;
  logic clr_evt;
  logic cap_a;
  logic cap_b;
  logic match_a;
  logic match_b;
  logic toggle;
  logic pin_b_used;
  logic [COUNT_W-1:0] cnt_inc;

  // Field decode
  always_comb begin
    run = ctrl_r[tcc_pkg::B_RUN];
    css = ctrl_r[tcc_pkg::B_CSS];
    a_cap = ctrl_r[tcc_pkg::B_A_CAP];
    b_cap = ctrl_r[tcc_pkg::B_B_CAP];
    esa = ctrl_r[tcc_pkg::F_ESA +: 2];
    esb = ctrl_r[tcc_pkg::F_ESB +: 2];
    pre_sel = ctrl_r[tcc_pkg::F_PRE +: tcc_pkg::PRE_W];
    if (ctrl_r[tcc_pkg::B_MODE]) begin
      mode = tcc_pkg::TCC_CLR_START;
    end else begin
      mode = tcc_pkg::TCC_FREE;
    end
  end

  // Control register write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (WR && ADDR == tcc_pkg::OFF_CTRL) begin
      ctrl_nxt = WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= tcc_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Edge qualification
  always_comb begin
    a_edge = tcc_pkg::edge_hit(esa, pin_a.rise, pin_a.fall);
    b_edge = tcc_pkg::edge_hit(esb, pin_b.rise, pin_b.fall);
    // Reverse phase swaps the edges; both-edges captures nothing
    if (esa == tcc_pkg::ES_BOTH) begin
      a_rev = 1'b0;
    end else begin
      a_rev = tcc_pkg::edge_hit(esa, pin_a.fall, pin_a.rise);
    end
  end

  // Timer core next state
  always_comb begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    cra_nxt = cra_r;
    crb_nxt = crb_r;
    irq_a_nxt = 1'b0;
    irq_b_nxt = 1'b0;
    cap_a = 1'b0;
    cap_b = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    clr_evt = 1'b0;
    toggle = 1'b0;
    cnt_inc = cnt_r + CNT_ONE;
    tick = run && (pre_r == pre_sel);
    // Prescaler restarts on each tick and while stopped
    if (!run) begin
      pre_nxt = PRE_ZERO;
    end else if (tick) begin
      pre_nxt = PRE_ZERO;
    end else begin
      pre_nxt = pre_r + PRE_ONE;
    end
    // Clear-and-start on pin A valid edge
    case (mode)
      tcc_pkg::TCC_CLR_START: begin
        clr_evt = run && a_edge;
      end
      default: begin
        clr_evt = 1'b0;
      end
    endcase
    // Counter: stopped reads zero, clear beats increment
    if (!run) begin
      cnt_nxt = CNT_ZERO;
    end else if (clr_evt) begin
      cnt_nxt = CNT_ZERO;
      pre_nxt = PRE_ZERO;
    end else if (tick) begin
      cnt_nxt = cnt_inc;
    end
    // Software writes; a capture in the same cycle wins
    if (WR && ADDR == tcc_pkg::OFF_CRA) begin
      cra_nxt = WDATA[COUNT_W-1:0];
    end
    if (WR && ADDR == tcc_pkg::OFF_CRB) begin
      crb_nxt = WDATA[COUNT_W-1:0];
    end
    // Register A in capture mode
    if (a_cap) begin
      if (css) begin
        cap_a = a_rev;
        irq_a_nxt = b_edge;
      end else begin
        cap_a = b_edge;
        irq_a_nxt = b_edge;
      end
    end else begin
      // Compare against the value the counter is about to take
      match_a = tick && !clr_evt && (cnt_inc == cra_r);
      irq_a_nxt = match_a;
    end
    // Register B: source select plays no part
    if (b_cap) begin
      cap_b = a_edge;
      irq_b_nxt = a_edge;
    end else begin
      match_b = tick && !clr_evt && (cnt_inc == crb_r);
      irq_b_nxt = match_b;
    end
    if (cap_a) begin
      cra_nxt = cnt_r;
    end
    if (cap_b) begin
      crb_nxt = cnt_r;
    end
    // Coincident causes invert the output only once
    toggle = (match_a && ctrl_r[tcc_pkg::B_TOG_A])
           || (match_b && ctrl_r[tcc_pkg::B_TOG_B])
           || (clr_evt && ctrl_r[tcc_pkg::B_TOG_CLR]);
  end

  // Output pin next state
  always_comb begin
    // Pin B detection is live whenever register A captures
    pin_b_used = a_cap;
    out_en_nxt = ctrl_r[tcc_pkg::B_OUT_EN] && !pin_b_used;
    // Disabled output parks at its reset level
    if (!out_en_nxt) begin
      out_nxt = tcc_pkg::OUT_RST;
    end else if (toggle) begin
      out_nxt = ~out_r;
    end else begin
      out_nxt = out_r;
    end
  end

  // Timer core registers
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pre_r <= PRE_ZERO;
      cnt_r <= CNT_ZERO;
      cra_r <= CNT_ZERO;
      crb_r <= CNT_ZERO;
      out_r <= tcc_pkg::OUT_RST;
      out_en_r <= 1'b0;
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      cra_r <= cra_nxt;
      crb_r <= crb_nxt;
      out_r <= out_nxt;
      out_en_r <= out_en_nxt;
      irq_a_r <= irq_a_nxt;
      irq_b_r <= irq_b_nxt;
    end
  end

  // Read decode; unmapped and idle cycles return zero
  always_comb begin
    rdata_nxt = '0;
    if (RD) begin
      if (ADDR == tcc_pkg::OFF_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (ADDR == tcc_pkg::OFF_CRA) begin
        rdata_nxt = {{(tcc_pkg::DATA_W-COUNT_W){1'b0}}, cra_r};
      end else if (ADDR == tcc_pkg::OFF_CRB) begin
        rdata_nxt = {{(tcc_pkg::DATA_W-COUNT_W){1'b0}}, crb_r};
      end else if (ADDR == tcc_pkg::OFF_COUNT) begin
        rdata_nxt = {{(tcc_pkg::DATA_W-COUNT_W){1'b0}}, cnt_r};
      end else if (ADDR == tcc_pkg::OFF_STAT) begin
        rdata_nxt[tcc_pkg::S_OUT] = out_r;
        rdata_nxt[tcc_pkg::S_OUT_EN] = out_en_r;
        rdata_nxt[tcc_pkg::S_PIN_A] = pin_a.level;
        rdata_nxt[tcc_pkg::S_PIN_B] = pin_b.level;
      end
    end
  end

  // Read data holds for one cycle only
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs come straight from flops
  assign RDATA = rdata_r;
  assign TIMER_OUTPUT_PIN = out_r;
  assign TIMER_OUTPUT_PIN_EN = out_en_r;
  assign INTERRUPT_REQUEST_A = irq_a_r;
  assign INTERRUPT_REQUEST_B = irq_b_r;

endmodule

// ### core/tcc_pkg.sv
package tcc_pkg;

  // Register bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CRA = 5'h04;
  localparam logic [4:0] OFF_CRB = 5'h08;
  localparam logic [4:0] OFF_COUNT = 5'h0C;
  localparam logic [4:0] OFF_STAT = 5'h10;

  // Control register bit positions
  localparam int B_RUN = 0;      // Count enable
  localparam int B_MODE = 1;     // 0 free-running, 1 clear-and-start
  localparam int B_CSS = 2;      // Capture source select bit
  localparam int B_A_CAP = 3;    // Register A: 1 capture, 0 compare
  localparam int B_B_CAP = 4;    // Register B: 1 capture, 0 compare
  localparam int B_TOG_A = 5;    // Invert output on A match
  localparam int B_TOG_B = 6;    // Invert output on B match
  localparam int B_TOG_CLR = 7;  // Invert output on clear-and-start clear
  localparam int B_OUT_EN = 8;   // Timer output pin enable
  localparam int F_ESA = 9;      // Input A edge select, 2 bits
  localparam int F_ESB = 11;     // Input B edge select, 2 bits
  localparam int F_PRE = 16;     // Prescaler divide minus one
  localparam int PRE_W = 4;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic OUT_RST = 1'b0;

  // Status register bit positions
  localparam int S_OUT = 0;
  localparam int S_OUT_EN = 1;
  localparam int S_PIN_A = 2;
  localparam int S_PIN_B = 3;

  // Edge select encodings
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_BOTH = 2'h3;

  // Counting modes, one-hot
  typedef enum logic [1:0] {
    TCC_FREE = 2'b01,
    TCC_CLR_START = 2'b10
  } tcc_mode_type;

  // Valid-edge decode; code 10 selects nothing
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    logic hit;
    hit = 1'b0;
    if (sel == ES_RISE) begin
      hit = rise;
    end else if (sel == ES_FALL) begin
      hit = fall;
    end else if (sel == ES_BOTH) begin
      hit = rise | fall;
    end
    return hit;
  endfunction

endpackage

// ### core/tcc_edge_if.sv
`timescale 1ns/1ns
// Filtered pin level and its edge pulses
interface tcc_edge_if;
  logic level; // Filtered pin level
  logic rise;  // One-cycle rising pulse
  logic fall;  // One-cycle falling pulse
  modport det (output level, output rise, output fall);
  modport user (input level, input rise, input fall);
endinterface

// ### core/tcc_edge_sync.sv
`timescale 1ns/1ns
// Pin synchroniser, agreement filter and edge detector
module tcc_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  tcc_edge_if.det ev
);

  logic s1_r; // First stage, read only by s2
  logic s2_r;
  logic s3_r;
  logic filt_r; // Accepted level
  logic filt_nxt;
  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;

  // Level changes only once stages two and three agree
  always_comb begin
    filt_nxt = (s2_r == s3_r) ? s2_r : filt_r;
    rise_nxt = filt_nxt & ~filt_r;
    fall_nxt = ~filt_nxt & filt_r;
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      filt_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign ev.level = filt_r;
  assign ev.rise = rise_r;
  assign ev.fall = fall_r;

endmodule

// ### tb/tcc_checker.sv
`timescale 1ns/1ns
// Pin and register port checks for the block
module tcc_checker #(
  parameter int COUNT_W = 16 // Same width as the block
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [tcc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tcc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [tcc_pkg::DATA_W-1:0] RDATA,
  input wire logic TIMER_INPUT_PIN_A,
  input wire logic TIMER_INPUT_PIN_B,
  input wire logic TIMER_OUTPUT_PIN,
  input wire logic TIMER_OUTPUT_PIN_EN,
  input wire logic INTERRUPT_REQUEST_A,
  input wire logic INTERRUPT_REQUEST_B
);
  localparam logic [31:0] CMASK = 32'h000F_1FFF; // Defined bits
  logic [31:0] ctrl_r; // Control word as seen on the bus
  logic [31:0] ctrl_nxt;
  logic cap_a; // Register A captures, so pin B is watched
  logic [1:0] esa;
  logic [1:0] esb;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  // Follow control writes; reserved bits are masked on compare
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (WR && ADDR == tcc_pkg::OFF_CTRL) begin
      ctrl_nxt = WDATA;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= tcc_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  assign cap_a = ctrl_r[tcc_pkg::B_A_CAP];
  assign esa = ctrl_r[tcc_pkg::F_ESA+:2];
  assign esb = ctrl_r[tcc_pkg::F_ESB+:2];
  idle_read_zero_a: assert property (!RD |=> RDATA == '0)
    else $error("read data not zero outside a read");
  ctrl_readback_a: assert property (RD && ADDR == tcc_pkg::OFF_CTRL
    |=> (RDATA & CMASK) == (ctrl_r & CMASK))
    else $error("control word read back wrong");
  out_off_low_a: assert property (
    !TIMER_OUTPUT_PIN_EN |-> !TIMER_OUTPUT_PIN)
    else $error("disabled output not low");
  pin_unused_a: assert property (
    cap_a && $past(cap_a) |-> !TIMER_OUTPUT_PIN_EN)
    else $error("output enabled while pin B watched");
  // Free running only: a clear may invert with no request
  toggle_cause_a: assert property (
    TIMER_OUTPUT_PIN_EN && $past(TIMER_OUTPUT_PIN_EN)
    && !$past(ctrl_r[tcc_pkg::B_MODE])
    && $changed(TIMER_OUTPUT_PIN)
    |-> INTERRUPT_REQUEST_A || INTERRUPT_REQUEST_B)
    else $error("output inverted without a match");
  pinb_irq_a: assert property (
    $rose(TIMER_INPUT_PIN_B) && cap_a && esb == tcc_pkg::ES_RISE
    |-> ##[3:7] INTERRUPT_REQUEST_A)
    else $error("pin B edge gave no request A");
  pina_irq_b_a: assert property (
    $rose(TIMER_INPUT_PIN_A) && ctrl_r[tcc_pkg::B_B_CAP]
    && esa == tcc_pkg::ES_RISE |-> ##[3:7] INTERRUPT_REQUEST_B)
    else $error("pin A edge gave no request B");
  rev_no_irq_a: assert property (
    $changed(TIMER_INPUT_PIN_A) && ctrl_r[tcc_pkg::B_CSS] && cap_a
    |=> !INTERRUPT_REQUEST_A [*7])
    else $error("reverse capture raised request A");
endmodule
bind tcc_top tcc_checker #(.COUNT_W(COUNT_W)) u_tcc_checker (.*);

// ### tb/tcc_pulse_src.sv
`timescale 1ns/1ns
// Pulse source on the two timer input pins
module tcc_pulse_src (
  input wire logic clk,
  output logic pin_a,
  output logic pin_b
);
  // Pins idle low from time zero
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // One pin changes after an edge, then holds well past the filter
  task automatic drive(input logic sel_b, input logic lvl);
    @(posedge clk);
    if (sel_b) begin
      pin_b <= lvl;
    end else begin
      pin_a <= lvl;
    end
    repeat (10) @(posedge clk);
  endtask
endmodule

// ### tb/tcc_top_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the capture and compare block
module tcc_top_tb;
  localparam int CW = 8; // Short counter so wraps come quickly
  localparam logic [31:0] SENT = 32'hA5; // Marks an untouched register
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [4:0] ADDR = 5'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic TIMER_INPUT_PIN_A;
  logic TIMER_INPUT_PIN_B;
  logic TIMER_OUTPUT_PIN;
  logic TIMER_OUTPUT_PIN_EN;
  logic INTERRUPT_REQUEST_A;
  logic INTERRUPT_REQUEST_B;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0; // Cycles so far
  int na = 0; // Request A pulses
  int nb = 0; // Request B pulses
  int nt = 0; // Output inversions
  logic out_q = 1'b0;
  tcc_top #(.COUNT_W(CW)) u_tcc_top (.*);
  tcc_pulse_src u_tcc_pulse_src (.clk(CORE_CLK),
    .pin_a(TIMER_INPUT_PIN_A), .pin_b(TIMER_INPUT_PIN_B));
  always #5 CORE_CLK = ~CORE_CLK;
  // Event tallies and the hang limit
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    na <= na + int'(INTERRUPT_REQUEST_A === 1'b1);
    nb <= nb + int'(INTERRUPT_REQUEST_B === 1'b1);
    nt <= nt + int'(TIMER_OUTPUT_PIN !== out_q);
    out_q <= TIMER_OUTPUT_PIN;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write, one strobe cycle
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  // Bus read; data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // Does edge code es select this edge
  function automatic logic hit(input logic [1:0] es, input logic r);
    return es == 2'h3 || es == {1'b0, r};
  endfunction
  initial begin
    logic [31:0] d;
    logic [31:0] d0;
    logic [1:0] es;
    logic css;
    logic h;
    logic ca;
    int t0;
    int a0;
    int b0;
    int p;
    void'($urandom(39257));
    repeat (20) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    // Reset values, read-only count, unmapped 0x14
    wr(tcc_pkg::OFF_COUNT, $urandom());
    wr(5'h14, $urandom());
    for (int i = 0; i < 6; i++) begin
      rd(5'(i * 4), d);
      chk("reset", 32'h0, d);
    end
    // Free count at full rate, reads spaced at random
    wr(tcc_pkg::OFF_CTRL, 32'h1);
    rd(tcc_pkg::OFF_COUNT, d0);
    t0 = cyc;
    repeat (12) begin
      repeat ($urandom_range(0, 300)) @(posedge CORE_CLK);
      rd(tcc_pkg::OFF_COUNT, d);
      chk("count", (d0 + 32'(cyc - t0)) & 32'hFF, d);
    end
    // Capture sweep, counter stopped at 0, both capture (0x118)
    for (int m = 0; m < 6; m++) begin
      css = m[0];
      es = (m >> 1) == 2 ? 2'h3 : 2'(m >> 1);
      wr(tcc_pkg::OFF_CTRL, (32'(css) << tcc_pkg::B_CSS) | 32'h118
         | (32'(es) << tcc_pkg::F_ESA) | (32'(es) << tcc_pkg::F_ESB));
      for (int ev = 0; ev < 4; ev++) begin
        wr(tcc_pkg::OFF_CRA, SENT);
        wr(tcc_pkg::OFF_CRB, SENT);
        a0 = na;
        b0 = nb;
        u_tcc_pulse_src.drive(ev[1], !ev[0]);
        h = hit(es, !ev[0]);
        ca = ev[1] ? !css && h : css && es != 2'h3 && hit(es, ev[0]);
        // Pin B requests are wanted here, so none is masked
        chk("irq a", 32'(ev[1] && h), 32'(na - a0));
        chk("irq b", 32'(!ev[1] && h), 32'(nb - b0));
        rd(tcc_pkg::OFF_CRA, d);
        chk("cra", ca ? 32'h0 : SENT, d);
        rd(tcc_pkg::OFF_CRB, d);
        chk("crb", !ev[1] && h ? 32'h0 : SENT, d);
        chk("out off", 32'h0, 32'(TIMER_OUTPUT_PIN_EN));
      end
    end
    // Two compares, free running, random prescale (0x161)
    p = $urandom_range(0, 3);
    wr(tcc_pkg::OFF_CRA, $urandom_range(0, 127));
    wr(tcc_pkg::OFF_CRB, $urandom_range(128, 255));
    wr(tcc_pkg::OFF_CTRL, 32'h161 | (32'(p) << tcc_pkg::F_PRE));
    repeat (20) @(posedge CORE_CLK);
    a0 = na;
    b0 = nb;
    t0 = nt;
    repeat (512 * (p + 1)) @(posedge CORE_CLK);
    chk("match a", 32'h2, 32'(na - a0));
    chk("match b", 32'h2, 32'(nb - b0));
    chk("toggles", 32'h4, 32'(nt - t0));
    chk("out en", 32'h1, 32'(TIMER_OUTPUT_PIN_EN));
    // Clear-and-start on pin A rise, count kept in B (0x39B)
    wr(tcc_pkg::OFF_CTRL, 32'h0);
    wr(tcc_pkg::OFF_CTRL, 32'h39B);
    repeat (100) @(posedge CORE_CLK);
    u_tcc_pulse_src.drive(1'b0, 1'b1);
    rd(tcc_pkg::OFF_COUNT, d);
    chk("cleared", 32'h1, 32'(d < 16));
    rd(tcc_pkg::OFF_CRB, d);
    chk("held", 32'h1, 32'(d > 100 && d < 112));
    chk("out busy", 32'h0, 32'(TIMER_OUTPUT_PIN_EN));
    print_verdict();
  end
endmodule
